// *** psr_pkg.sv ***
package psr_pkg;
  // Register indices selected by the status-access instructions.
  localparam logic [7:0] PSR_RAM_BASE   = 8'h00;
  localparam logic [7:0] PSR_VEC_BASE   = 8'h01;
  localparam logic [7:0] PSR_TILE_CTRL  = 8'h02;
  localparam logic [7:0] PSR_BOOT_STAT  = 8'h03;
  localparam logic [7:0] PSR_SEC_CFG    = 8'h05;
  localparam logic [7:0] PSR_RO_CTRL    = 8'h06;
  localparam logic [7:0] PSR_RO_CNT0    = 8'h07;
  localparam logic [7:0] PSR_RO_CNT3    = 8'h0A;
  localparam logic [7:0] PSR_RAM_SIZE   = 8'h0C;
  localparam logic [7:0] PSR_DBG_SSW    = 8'h10;
  localparam logic [7:0] PSR_DBG_SPC    = 8'h11;
  localparam logic [7:0] PSR_DBG_SSP    = 8'h12;
  localparam logic [7:0] PSR_DBG_THR    = 8'h13;
  localparam logic [7:0] PSR_DBG_REG    = 8'h14;
  localparam logic [7:0] PSR_DBG_CAUSE  = 8'h15;
  localparam logic [7:0] PSR_DBG_DATA   = 8'h16;
  localparam logic [7:0] PSR_DBG_STOP   = 8'h18;
  localparam logic [7:0] PSR_SCRATCH    = 8'h20;
  localparam logic [7:0] PSR_IBRK_ADDR  = 8'h30;
  localparam logic [7:0] PSR_IBRK_CTRL  = 8'h40;
  localparam logic [7:0] PSR_DWP_ADDR1  = 8'h50;
  localparam logic [7:0] PSR_DWP_ADDR2  = 8'h60;
  localparam logic [7:0] PSR_DWP_CTRL   = 8'h70;
  localparam logic [7:0] PSR_RWP_MASK   = 8'h80;
  localparam logic [7:0] PSR_RWP_VALUE  = 8'h90;
  localparam logic [7:0] PSR_RWP_CTRL   = 8'h9C;
  localparam int         PSR_SCRATCH_N  = 8;
  localparam int         PSR_WP_N       = 4;
  // Security word fields.
  localparam int         SEC_WLOCK_BIT  = 31;
  localparam int         SEC_GDBG_BIT   = 14;
  localparam int         SEC_LOCKALL_BIT = 12;
  localparam int         SEC_BOOTOTP_BIT = 5;
  localparam int         SEC_JTAGCFG_BIT = 4;
  localparam int         SEC_JTAGTAP_BIT = 0;
  localparam logic [31:0] SEC_WMASK     = 32'h80005FB1;
  // Writable masks of the narrow debug registers, then the RAM size read mask and the common reset value.
  localparam logic [31:0] THR_WMASK     = 32'h000000FF;
  localparam logic [31:0] REG_WMASK     = 32'h0000001F;
  localparam logic [31:0] CAUSE_WMASK   = 32'h0003FF07;
  localparam logic [31:0] STOP_WMASK    = 32'h000000FF;
  localparam logic [31:0] IBC_WMASK     = 32'h00FF0003;
  localparam logic [31:0] RAMSZ_MASK    = 32'hFFFFFFFC;
  localparam logic [31:0] ZERO_RESET    = 32'h00000000;
  // Debug causes.
  localparam logic [2:0]  CAUSE_NONE    = 3'h0;
  localparam logic [2:0]  CAUSE_HOST    = 3'h1;
  localparam logic [2:0]  CAUSE_DEBUG_CALL_INSTRUCTION   = 3'h2;
  localparam logic [2:0]  CAUSE_IBRK    = 3'h3;
  localparam logic [2:0]  CAUSE_DWATCH  = 3'h4;
  localparam logic [2:0]  CAUSE_RWATCH  = 3'h5;
endpackage

// *** psr_regs.sv ***
// How it works
// - Processor reads and writes each register by its numeric index.
// - Boot status is read-only: processor number, override flag, PLL mode pins.
// - Boot status bit 5 shows second core powered off.
// - Boot status bit 4 tells boot ROM to skip OTP level polling.
// - Boot status bit 3 boot-from-RAM, bit 2 boot-from-JTAG.
// - Security register loads a copy of the OTP security word.
// - Security bit 31 set blocks further writes to security register.
// - Security bit 14 disables global debug access.
// - Security bit 12 locks all OTP sectors, bits 11:8 each lock one.
// - Security bit 5 forces boot image from OTP.
// - Security bit 4 blocks JTAG config access, bit 0 blocks JTAG debug TAP.
// - Ring oscillator registers show a 16-bit count, upper bits zero.
// - Ring oscillator counts are not cleared by system reset.
// - RAM size is read-only, bytes in bits 31:2, bits 1:0 zero.
// - On debug entry the saved status register captures the status word.
// - Fetch operand one holds thread number in bits 7:0.
// - Fetch operand two holds register number in bits 4:0.
// - Debug cause resets to 0 and records host, call, break, watch codes.
// - Bits 17:16 hold lowest triggering unit index, 0 for host or call.
// - Bits 15:8 hold raising thread number, 0 for host requests.
// - Threads set in core-stop register do not run after debug return.
`timescale 1ns/1ps
`default_nettype none
module psr_regs
  import psr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ps_wr,
  input  wire logic        ps_rd,
  input  wire logic [7:0]  ps_idx,
  input  wire logic [31:0] ps_wdata,
  output logic      [31:0] ps_rdata,
  output logic             ps_rvalid,
  input  wire logic        debug_mode,
  input  wire logic        debug_return,
  input  wire logic        debug_entry,
  input  wire logic [31:0] status_word,
  input  wire logic [31:0] pc_value,
  input  wire logic [31:0] sp_value,
  input  wire logic        dbg_host_req,
  input  wire logic        dbg_call,
  input  wire logic [3:0]  dbg_ibrk_hit,
  input  wire logic [3:0]  dbg_dwatch_hit,
  input  wire logic [3:0]  dbg_rwatch_hit,
  input  wire logic [7:0]  dbg_thread,
  input  wire logic [31:0] dbg_event_data,
  input  wire logic        otp_load,
  input  wire logic [31:0] otp_sec_word,
  input  wire logic [7:0]  proc_number,
  input  wire logic        boot_override,
  input  wire logic        core1_off,
  input  wire logic        skip_otp_poll,
  input  wire logic        boot_from_ram,
  input  wire logic        boot_from_jtag,
  input  wire logic [1:0]  pll_mode_pins,
  input  wire logic [3:0]  ring_osc_tick,
  input  wire logic [31:0] ram_size_bytes,
  output logic             global_debug_off,
  output logic             otp_lock_all,
  output logic      [3:0]  otp_sector_lock,
  output logic             boot_from_otp,
  output logic             jtag_cfg_off,
  output logic             jtag_tap_off,
  output logic      [7:0]  thread_stop,
  output logic      [7:0]  fetch_thread,
  output logic      [4:0]  fetch_reg,
  output logic      [31:0] ram_base,
  output logic      [31:0] vector_base,
  output logic      [31:0] tile_ctrl,
  output logic      [31:0] ring_osc_ctrl
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] msk);
    return (old & ~msk) | (nw & msk);
  endfunction

  function automatic logic [1:0] lowest(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = PSR_WP_N - 1; i >= 0; i--) begin
      if (v[i]) r = 2'(i);
    end
    return r;
  endfunction

  logic [31:0] ram_base_r, ram_base_nxt, vec_base_r, vec_base_nxt;
  logic [31:0] tile_ctrl_r, tile_ctrl_nxt, ro_ctrl_r, ro_ctrl_nxt;
  logic [31:0] sec_r, sec_nxt, ssw_r, ssw_nxt, spc_r, spc_nxt, ssp_r, ssp_nxt;
  logic [31:0] thr_r, thr_nxt, reg_r, reg_nxt, cause_r, cause_nxt;
  logic [31:0] ddata_r, ddata_nxt, stop_r, stop_nxt;
  logic [31:0] scr_r [PSR_SCRATCH_N];
  logic [31:0] scr_nxt [PSR_SCRATCH_N];
  logic [31:0] iba_r [PSR_WP_N], ibc_r [PSR_WP_N], dw1_r [PSR_WP_N], dw2_r [PSR_WP_N];
  logic [31:0] dwc_r [PSR_WP_N], rwm_r [PSR_WP_N], rwv_r [PSR_WP_N], rwc_r [PSR_WP_N];
  logic [31:0] iba_nxt [PSR_WP_N], ibc_nxt [PSR_WP_N], dw1_nxt [PSR_WP_N];
  logic [31:0] dw2_nxt [PSR_WP_N], dwc_nxt [PSR_WP_N], rwm_nxt [PSR_WP_N];
  logic [31:0] rwv_nxt [PSR_WP_N], rwc_nxt [PSR_WP_N];
  logic [15:0] rosc_r [PSR_WP_N];
  logic [31:0] rdata_r, rdata_nxt;
  logic        rvalid_r;
  logic        dwr;
  logic        any_hw;

  assign dwr    = ps_wr & debug_mode;
  assign any_hw = |{dbg_ibrk_hit, dbg_dwatch_hit, dbg_rwatch_hit};

  always_comb begin
    ram_base_nxt  = ram_base_r;
    vec_base_nxt  = vec_base_r;
    tile_ctrl_nxt = tile_ctrl_r;
    ro_ctrl_nxt   = ro_ctrl_r;
    sec_nxt       = sec_r;
    ssw_nxt       = ssw_r;
    spc_nxt       = spc_r;
    ssp_nxt       = ssp_r;
    thr_nxt       = thr_r;
    reg_nxt       = reg_r;
    cause_nxt     = cause_r;
    ddata_nxt     = ddata_r;
    stop_nxt      = stop_r;
    scr_nxt       = scr_r;
    iba_nxt       = iba_r;
    ibc_nxt       = ibc_r;
    dw1_nxt       = dw1_r;
    dw2_nxt       = dw2_r;
    dwc_nxt       = dwc_r;
    rwm_nxt       = rwm_r;
    rwv_nxt       = rwv_r;
    rwc_nxt       = rwc_r;
    if (ps_wr) begin
      unique case (ps_idx)
        PSR_RAM_BASE:  ram_base_nxt = ps_wdata;
        PSR_VEC_BASE:  vec_base_nxt = ps_wdata;
        PSR_TILE_CTRL: tile_ctrl_nxt = ps_wdata;
        PSR_RO_CTRL:   ro_ctrl_nxt = ps_wdata;
        PSR_SEC_CFG: begin
          if (!sec_r[SEC_WLOCK_BIT]) sec_nxt = merge(sec_r, ps_wdata, SEC_WMASK);
        end
        default: ;
      endcase
    end
    if (dwr) begin
      unique case (ps_idx)
        PSR_DBG_SSW:   ssw_nxt = ps_wdata;
        PSR_DBG_SPC:   spc_nxt = ps_wdata;
        PSR_DBG_SSP:   ssp_nxt = ps_wdata;
        PSR_DBG_THR:   thr_nxt = ps_wdata & THR_WMASK;
        PSR_DBG_REG:   reg_nxt = ps_wdata & REG_WMASK;
        PSR_DBG_CAUSE: cause_nxt = ps_wdata & CAUSE_WMASK;
        PSR_DBG_DATA:  ddata_nxt = ps_wdata;
        PSR_DBG_STOP:  stop_nxt = ps_wdata & STOP_WMASK;
        default: begin
          for (int i = 0; i < PSR_SCRATCH_N; i++) begin
            if (ps_idx == PSR_SCRATCH + 8'(i)) scr_nxt[i] = ps_wdata;
          end
          for (int i = 0; i < PSR_WP_N; i++) begin
            if (ps_idx == PSR_IBRK_ADDR + 8'(i)) iba_nxt[i] = ps_wdata;
            if (ps_idx == PSR_IBRK_CTRL + 8'(i)) ibc_nxt[i] = ps_wdata & IBC_WMASK;
            if (ps_idx == PSR_DWP_ADDR1 + 8'(i)) dw1_nxt[i] = ps_wdata;
            if (ps_idx == PSR_DWP_ADDR2 + 8'(i)) dw2_nxt[i] = ps_wdata;
            if (ps_idx == PSR_DWP_CTRL + 8'(i))  dwc_nxt[i] = ps_wdata;
            if (ps_idx == PSR_RWP_MASK + 8'(i))  rwm_nxt[i] = ps_wdata;
            if (ps_idx == PSR_RWP_VALUE + 8'(i)) rwv_nxt[i] = ps_wdata;
            if (ps_idx == PSR_RWP_CTRL + 8'(i))  rwc_nxt[i] = ps_wdata;
          end
        end
      endcase
    end
    // The OTP copy wins over a software write in the same cycle.
    if (otp_load) sec_nxt = otp_sec_word & SEC_WMASK;
    // Debug entry is a hardware event and wins over software writes.
    if (debug_entry) begin
      ssw_nxt = status_word;
      spc_nxt = pc_value;
      ssp_nxt = sp_value;
      cause_nxt = ZERO_RESET;
      if (dbg_host_req) begin
        cause_nxt[2:0] = CAUSE_HOST;
      end else if (dbg_call) begin
        cause_nxt[2:0]  = CAUSE_DEBUG_CALL_INSTRUCTION;
        cause_nxt[15:8] = dbg_thread;
      end else if (any_hw) begin
        cause_nxt[15:8] = dbg_thread;
        if (|dbg_ibrk_hit) begin
          cause_nxt[2:0]   = CAUSE_IBRK;
          cause_nxt[17:16] = lowest(dbg_ibrk_hit);
        end else if (|dbg_dwatch_hit) begin
          cause_nxt[2:0]   = CAUSE_DWATCH;
          cause_nxt[17:16] = lowest(dbg_dwatch_hit);
          ddata_nxt        = dbg_event_data;
        end else begin
          cause_nxt[2:0]   = CAUSE_RWATCH;
          cause_nxt[17:16] = lowest(dbg_rwatch_hit);
          ddata_nxt        = dbg_event_data;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ram_base_r  <= ZERO_RESET;
      vec_base_r  <= ZERO_RESET;
      tile_ctrl_r <= ZERO_RESET;
      ro_ctrl_r   <= ZERO_RESET;
      sec_r       <= ZERO_RESET;
      ssw_r       <= ZERO_RESET;
      spc_r       <= ZERO_RESET;
      ssp_r       <= ZERO_RESET;
      thr_r       <= ZERO_RESET;
      reg_r       <= ZERO_RESET;
      cause_r     <= ZERO_RESET;
      ddata_r     <= ZERO_RESET;
      stop_r      <= ZERO_RESET;
      for (int i = 0; i < PSR_SCRATCH_N; i++) scr_r[i] <= ZERO_RESET;
      for (int i = 0; i < PSR_WP_N; i++) begin
        iba_r[i] <= ZERO_RESET;
        ibc_r[i] <= ZERO_RESET;
        dw1_r[i] <= ZERO_RESET;
        dw2_r[i] <= ZERO_RESET;
        dwc_r[i] <= ZERO_RESET;
        rwm_r[i] <= ZERO_RESET;
        rwv_r[i] <= ZERO_RESET;
        rwc_r[i] <= ZERO_RESET;
      end
    end else begin
      ram_base_r  <= ram_base_nxt;
      vec_base_r  <= vec_base_nxt;
      tile_ctrl_r <= tile_ctrl_nxt;
      ro_ctrl_r   <= ro_ctrl_nxt;
      sec_r       <= sec_nxt;
      ssw_r       <= ssw_nxt;
      spc_r       <= spc_nxt;
      ssp_r       <= ssp_nxt;
      thr_r       <= thr_nxt;
      reg_r       <= reg_nxt;
      cause_r     <= cause_nxt;
      ddata_r     <= ddata_nxt;
      stop_r      <= stop_nxt;
      scr_r       <= scr_nxt;
      iba_r       <= iba_nxt;
      ibc_r       <= ibc_nxt;
      dw1_r       <= dw1_nxt;
      dw2_r       <= dw2_nxt;
      dwc_r       <= dwc_nxt;
      rwm_r       <= rwm_nxt;
      rwv_r       <= rwv_nxt;
      rwc_r       <= rwc_nxt;
    end
  end

  // Counters sit outside the system reset so a measurement survives it. A write to the
  // oscillator control word restarts them; until then they are unknown in simulation.
  always_ff @(posedge mclk) begin
    for (int i = 0; i < PSR_WP_N; i++) begin
      if (ps_wr && ps_idx == PSR_RO_CTRL) rosc_r[i] <= 16'h0000;
      else if (ring_osc_tick[i] && ro_ctrl_r[0]) rosc_r[i] <= rosc_r[i] + 16'h0001;
    end
  end

  always_comb begin
    rdata_nxt = ZERO_RESET;
    unique case (ps_idx)
      PSR_RAM_BASE:  rdata_nxt = ram_base_r;
      PSR_VEC_BASE:  rdata_nxt = vec_base_r;
      PSR_TILE_CTRL: rdata_nxt = tile_ctrl_r;
      PSR_BOOT_STAT: begin
        rdata_nxt[23:16] = proc_number;
        rdata_nxt[8]     = boot_override;
        rdata_nxt[5]     = core1_off;
        rdata_nxt[4]     = skip_otp_poll;
        rdata_nxt[3]     = boot_from_ram;
        rdata_nxt[2]     = boot_from_jtag;
        rdata_nxt[1:0]   = pll_mode_pins;
      end
      PSR_SEC_CFG:   rdata_nxt = sec_r;
      PSR_RO_CTRL:   rdata_nxt = ro_ctrl_r;
      PSR_RAM_SIZE:  rdata_nxt = ram_size_bytes & RAMSZ_MASK;
      PSR_DBG_SSW:   rdata_nxt = ssw_r;
      PSR_DBG_SPC:   rdata_nxt = spc_r;
      PSR_DBG_SSP:   rdata_nxt = ssp_r;
      PSR_DBG_THR:   rdata_nxt = thr_r;
      PSR_DBG_REG:   rdata_nxt = reg_r;
      PSR_DBG_CAUSE: rdata_nxt = cause_r;
      PSR_DBG_DATA:  rdata_nxt = ddata_r;
      PSR_DBG_STOP:  rdata_nxt = stop_r;
      default: begin
        for (int i = 0; i < PSR_WP_N; i++) begin
          if (ps_idx == PSR_RO_CNT0 + 8'(i)) rdata_nxt = {16'h0000, rosc_r[i]};
          if (ps_idx == PSR_IBRK_ADDR + 8'(i)) rdata_nxt = iba_r[i];
          if (ps_idx == PSR_IBRK_CTRL + 8'(i)) rdata_nxt = ibc_r[i];
          if (ps_idx == PSR_DWP_ADDR1 + 8'(i)) rdata_nxt = dw1_r[i];
          if (ps_idx == PSR_DWP_ADDR2 + 8'(i)) rdata_nxt = dw2_r[i];
          if (ps_idx == PSR_DWP_CTRL + 8'(i))  rdata_nxt = dwc_r[i];
          if (ps_idx == PSR_RWP_MASK + 8'(i))  rdata_nxt = rwm_r[i];
          if (ps_idx == PSR_RWP_VALUE + 8'(i)) rdata_nxt = rwv_r[i];
          if (ps_idx == PSR_RWP_CTRL + 8'(i))  rdata_nxt = rwc_r[i];
        end
        for (int i = 0; i < PSR_SCRATCH_N; i++) begin
          if (ps_idx == PSR_SCRATCH + 8'(i)) rdata_nxt = scr_r[i];
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_r  <= ZERO_RESET;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= ps_rd ? rdata_nxt : rdata_r;
      rvalid_r <= ps_rd;
    end
  end

  assign ps_rdata         = rdata_r;
  assign ps_rvalid        = rvalid_r;
  assign global_debug_off = sec_r[SEC_GDBG_BIT];
  assign otp_lock_all     = sec_r[SEC_LOCKALL_BIT];
  assign otp_sector_lock  = sec_r[11:8];
  assign boot_from_otp    = sec_r[SEC_BOOTOTP_BIT];
  assign jtag_cfg_off     = sec_r[SEC_JTAGCFG_BIT];
  assign jtag_tap_off     = sec_r[SEC_JTAGTAP_BIT];
  // Stop vector only acts outside debug mode, so the debugger can single step.
  assign thread_stop      = debug_mode ? 8'h00 : stop_r[7:0];
  assign fetch_thread     = thr_r[7:0];
  assign fetch_reg        = reg_r[4:0];
  assign ram_base         = ram_base_r;
  assign vector_base      = vec_base_r;
  assign tile_ctrl        = tile_ctrl_r;
  assign ring_osc_ctrl    = ro_ctrl_r;

  chk_sec_write_lock: assert property (@(posedge mclk) disable iff (!nrst)
    sec_r[SEC_WLOCK_BIT] && !otp_load |=> $stable(sec_r))
    else $error("security word changed while write locked");
  chk_debug_only_write: assert property (@(posedge mclk) disable iff (!nrst)
    !debug_mode && !debug_entry && ps_wr && ps_idx == PSR_DBG_STOP |=> $stable(stop_r))
    else $error("debug register written outside debug mode");
  chk_saved_status: assert property (@(posedge mclk) disable iff (!nrst)
    debug_entry |=> ssw_r == $past(status_word))
    else $error("saved status not captured on debug entry");
  chk_host_cause: assert property (@(posedge mclk) disable iff (!nrst)
    debug_entry && dbg_host_req |=> cause_r == 32'h00000001)
    else $error("host cause wrong");
  chk_lowest_index: assert property (@(posedge mclk) disable iff (!nrst)
    debug_entry && !dbg_host_req && !dbg_call && dbg_ibrk_hit != 4'h0
    |=> cause_r[2:0] == CAUSE_IBRK
        && (($past(dbg_ibrk_hit) >> cause_r[17:16]) & 4'h1) == 4'h1
        && ($past(dbg_ibrk_hit) & ~(4'hF << cause_r[17:16])) == 4'h0)
    else $error("breakpoint index not lowest");
  chk_cause_thread: assert property (@(posedge mclk) disable iff (!nrst)
    debug_entry && !dbg_host_req && (dbg_call || any_hw) |=> cause_r[15:8] == $past(dbg_thread))
    else $error("debug cause thread number wrong");
  chk_osc_restart: assert property (@(posedge mclk) disable iff (!nrst)
    ps_wr && ps_idx == PSR_RO_CTRL |=> rosc_r[0] == 16'h0000 && rosc_r[3] == 16'h0000)
    else $error("oscillator count not restarted");
  chk_read_zero_high: assert property (@(posedge mclk) disable iff (!nrst)
    ps_rd && ps_idx >= PSR_RO_CNT0 && ps_idx <= PSR_RO_CNT3 |=> ps_rdata[31:16] == 16'h0000)
    else $error("oscillator reserved bits nonzero");
  chk_ram_size_low: assert property (@(posedge mclk) disable iff (!nrst)
    ps_rd && ps_idx == PSR_RAM_SIZE |=> ps_rvalid && ps_rdata[1:0] == 2'h0)
    else $error("ram size low bits nonzero");
  chk_boot_pll: assert property (@(posedge mclk) disable iff (!nrst)
    ps_rd && ps_idx == PSR_BOOT_STAT
    |=> ps_rdata[1:0] == $past(pll_mode_pins) && ps_rdata[23:16] == $past(proc_number))
    else $error("boot status fields wrong");
endmodule
`default_nettype wire

// *** tb_processor_status_debug_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module tb_processor_status_debug_regs;
  import psr_pkg::*;
  logic        mclk, nrst, ps_wr, ps_rd, ps_rvalid, debug_mode, debug_return, debug_entry;
  logic        dbg_host_req, dbg_call, otp_load, boot_override, core1_off, skip_otp_poll;
  logic        boot_from_ram, boot_from_jtag, global_debug_off, otp_lock_all;
  logic        boot_from_otp, jtag_cfg_off, jtag_tap_off;
  logic [1:0]  pll_mode_pins;
  logic [3:0]  dbg_ibrk_hit, dbg_dwatch_hit, dbg_rwatch_hit, ring_osc_tick, otp_sector_lock;
  logic [4:0]  fetch_reg;
  logic [7:0]  ps_idx, dbg_thread, proc_number, thread_stop, fetch_thread;
  logic [11:0] hits;
  logic [31:0] ps_wdata, ps_rdata, status_word, pc_value, sp_value, dbg_event_data;
  logic [31:0] otp_sec_word, ram_size_bytes, ram_base, vector_base, tile_ctrl, ring_osc_ctrl;
  logic [31:0] d;
  logic [31:0] m [256];
  logic [31:0] cnt [4];
  logic [7:0]  idx_tab [24] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h0B, 8'h0F, 8'h10, 8'h11,
                                8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h20,
                                8'h27, 8'h30, 8'h40, 8'h50, 8'h60, 8'h80, 8'h90, 8'hE0};
  int          mismatches, checked, cyc;
  int          cnt_m [4];
  logic        ro_on, ro_clr;

  psr_regs psr_regs_i (.mclk(mclk), .nrst(nrst), .ps_wr(ps_wr), .ps_rd(ps_rd), .ps_idx(ps_idx),
    .ps_wdata(ps_wdata), .ps_rdata(ps_rdata), .ps_rvalid(ps_rvalid), .debug_mode(debug_mode),
    .debug_return(debug_return), .debug_entry(debug_entry), .status_word(status_word),
    .pc_value(pc_value), .sp_value(sp_value), .dbg_host_req(dbg_host_req), .dbg_call(dbg_call),
    .dbg_ibrk_hit(dbg_ibrk_hit), .dbg_dwatch_hit(dbg_dwatch_hit), .dbg_rwatch_hit(dbg_rwatch_hit),
    .dbg_thread(dbg_thread), .dbg_event_data(dbg_event_data), .otp_load(otp_load),
    .otp_sec_word(otp_sec_word), .proc_number(proc_number), .boot_override(boot_override),
    .core1_off(core1_off), .skip_otp_poll(skip_otp_poll), .boot_from_ram(boot_from_ram),
    .boot_from_jtag(boot_from_jtag), .pll_mode_pins(pll_mode_pins),
    .ring_osc_tick(ring_osc_tick), .ram_size_bytes(ram_size_bytes),
    .global_debug_off(global_debug_off), .otp_lock_all(otp_lock_all),
    .otp_sector_lock(otp_sector_lock), .boot_from_otp(boot_from_otp),
    .jtag_cfg_off(jtag_cfg_off), .jtag_tap_off(jtag_tap_off), .thread_stop(thread_stop),
    .fetch_thread(fetch_thread), .fetch_reg(fetch_reg), .ram_base(ram_base),
    .vector_base(vector_base), .tile_ctrl(tile_ctrl), .ring_osc_ctrl(ring_osc_ctrl));

  always #4 mclk = ~mclk;

  // Oscillator count model: restart request and enable as they stand before each rising edge.
  always @(negedge mclk) begin
    ro_clr = ps_wr && ps_idx == PSR_RO_CTRL;
    ro_on  = nrst && m[PSR_RO_CTRL][0];
  end

  always @(posedge mclk) begin
    for (int c = 0; c < 4; c++) begin
      if (ro_clr) cnt_m[c] = 0;
      else if (ro_on && ring_osc_tick[c]) cnt_m[c] = cnt_m[c] + 1;
    end
  end

  // Writable bits of each index as the model sees them; zero means the write is dropped.
  function automatic logic [31:0] wmask(input logic [7:0] i, input logic dm);
    if (i <= PSR_TILE_CTRL || i == PSR_RO_CTRL) return 32'hFFFFFFFF;
    if (i == PSR_SEC_CFG) return m[i][SEC_WLOCK_BIT] ? 32'h00000000 : SEC_WMASK;
    if (!dm) return 32'h00000000;
    case (i)
      PSR_DBG_THR: return THR_WMASK;
      PSR_DBG_REG: return REG_WMASK;
      PSR_DBG_CAUSE: return CAUSE_WMASK;
      PSR_DBG_STOP: return STOP_WMASK;
      PSR_IBRK_CTRL: return IBC_WMASK;
      PSR_DBG_SSW, PSR_DBG_SPC, PSR_DBG_SSP, PSR_DBG_DATA, PSR_SCRATCH, 8'h27, PSR_IBRK_ADDR,
        PSR_DWP_ADDR1, PSR_DWP_ADDR2, PSR_RWP_MASK, PSR_RWP_VALUE: return 32'hFFFFFFFF;
      default: return 32'h00000000;
    endcase
  endfunction

  function automatic logic [1:0] low(input logic [3:0] v);
    low = 2'h0;
    for (int b = 3; b >= 0; b--)
      if (v[b]) low = 2'(b);
  endfunction

  task automatic wr(input logic [7:0] i, input logic [31:0] v, input logic dm);
    @(posedge mclk);
    ps_wr <= 1'b1;
    ps_idx <= i;
    ps_wdata <= v;
    debug_mode <= dm;
    @(posedge mclk);
    ps_wr <= 1'b0;
    m[i] = (m[i] & ~wmask(i, dm)) | (v & wmask(i, dm));
  endtask

  task automatic rd(input logic [7:0] i, output logic [31:0] v);
    @(posedge mclk);
    ps_rd <= 1'b1;
    ps_idx <= i;
    @(posedge mclk);
    ps_rd <= 1'b0;
    #1;
    `CHK("read valid", 1'b1, ps_rvalid)
    v = ps_rdata;
  endtask

  task automatic rchk(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] v;
    rd(i, v);
    `CHK("read data", e, v)
  endtask

  task automatic outs();
    #1;
    `CHK("ram_base", m[PSR_RAM_BASE], ram_base)
    `CHK("vector_base", m[PSR_VEC_BASE], vector_base)
    `CHK("tile_ctrl", m[PSR_TILE_CTRL], tile_ctrl)
    `CHK("fetch_thread", m[PSR_DBG_THR][7:0], fetch_thread)
    `CHK("fetch_reg", m[PSR_DBG_REG][4:0], fetch_reg)
    `CHK("thread_stop", debug_mode ? 8'h00 : m[PSR_DBG_STOP][7:0], thread_stop)
    `CHK("ring_osc_ctrl", m[PSR_RO_CTRL], ring_osc_ctrl)
    `CHK("debug off", m[5][14], global_debug_off)
    `CHK("otp locks", m[5][12:8], {otp_lock_all, otp_sector_lock})
    `CHK("boot from otp", m[5][5], boot_from_otp)
    `CHK("jtag off", {m[5][4], m[5][0]}, {jtag_cfg_off, jtag_tap_off})
  endtask

  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    {mclk, nrst, ps_wr, ps_rd, debug_mode, debug_return, debug_entry, dbg_host_req} = '0;
    {dbg_call, otp_load, boot_override, core1_off, skip_otp_poll, boot_from_ram} = '0;
    {boot_from_jtag, pll_mode_pins, dbg_ibrk_hit, dbg_dwatch_hit, dbg_rwatch_hit} = '0;
    {ring_osc_tick, ps_idx, dbg_thread, proc_number, ps_wdata, status_word} = '0;
    {pc_value, sp_value, dbg_event_data, otp_sec_word, ram_size_bytes} = '0;
    foreach (m[j]) m[j] = 32'h00000000;
    void'($urandom(51964));
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    // Boot status mirrors its pins and ignores writes; RAM size drops its two low bits.
    {proc_number, boot_override, core1_off, skip_otp_poll, boot_from_ram, boot_from_jtag,
      pll_mode_pins} <= 15'($urandom);
    ram_size_bytes <= $urandom;
    wr(PSR_BOOT_STAT, $urandom, 1'b1);
    rchk(PSR_BOOT_STAT, {8'h00, proc_number, 7'h00, boot_override, 2'h0, core1_off,
      skip_otp_poll, boot_from_ram, boot_from_jtag, pll_mode_pins});
    rchk(PSR_RAM_SIZE, ram_size_bytes & RAMSZ_MASK);
    @(posedge mclk);
    otp_sec_word <= $urandom & 32'h7FFFFFFF;
    otp_load <= 1'b1;
    @(posedge mclk);
    otp_load <= 1'b0;
    m[PSR_SEC_CFG] = otp_sec_word & SEC_WMASK;
    outs();
    rchk(PSR_SEC_CFG, m[PSR_SEC_CFG]);
    wr(PSR_SEC_CFG, $urandom & 32'h7FFFFFFF, 1'b0);
    outs();
    wr(PSR_SEC_CFG, $urandom | 32'h80000000, 1'b0);
    wr(PSR_SEC_CFG, $urandom, 1'b0);
    outs();
    rchk(PSR_SEC_CFG, m[PSR_SEC_CFG]);
    wr(PSR_RO_CTRL, 32'h00000001, 1'b0);
    for (int n = 0; n < 150; n++) begin
      wr(idx_tab[$urandom_range(23)], $urandom, 1'($urandom));
      ring_osc_tick <= 4'($urandom);
      outs();
    end
    @(posedge mclk);
    ring_osc_tick <= 4'h0;
    foreach (idx_tab[t]) rchk(idx_tab[t], m[idx_tab[t]]);
    // Each pass also raises every lower-priority cause, so only the top one may be recorded.
    for (int k = 0; k < 5; k++) begin
      hits = {4'($urandom) | 4'h8, 4'($urandom) | 4'h8, 4'($urandom) | 4'h8};
      @(posedge mclk);
      dbg_host_req <= (k == 0);
      dbg_call <= (k <= 1);
      dbg_ibrk_hit <= (k <= 2) ? hits[11:8] : 4'h0;
      dbg_dwatch_hit <= (k <= 3) ? hits[7:4] : 4'h0;
      dbg_rwatch_hit <= hits[3:0];
      dbg_thread <= 8'($urandom);
      {status_word, pc_value, sp_value} <= {$urandom, $urandom, $urandom};
      dbg_event_data <= $urandom;
      debug_entry <= 1'b1;
      @(posedge mclk);
      debug_entry <= 1'b0;
      m[PSR_DBG_SSW] = status_word;
      m[PSR_DBG_SPC] = pc_value;
      m[PSR_DBG_SSP] = sp_value;
      m[PSR_DBG_CAUSE] = {14'h0, low(k == 2 ? hits[11:8] : k == 3 ? hits[7:4] :
        k == 4 ? hits[3:0] : 4'h0), k == 0 ? 8'h00 : dbg_thread, 5'h00, 3'(k + 1)};
      if (k >= 3) m[PSR_DBG_DATA] = dbg_event_data;
      rchk(PSR_DBG_SSW, m[PSR_DBG_SSW]);
      rchk(PSR_DBG_CAUSE, m[PSR_DBG_CAUSE]);
      rchk(PSR_DBG_DATA, m[PSR_DBG_DATA]);
    end
    for (int c = 0; c < 4; c++) begin
      rd(PSR_RO_CNT0 + 8'(c), cnt[c]);
      `CHK("count upper bits", 16'h0000, cnt[c][31:16])
      `CHK("osc count", 16'(cnt_m[c]), cnt[c][15:0])
    end
    // A mid-run reset must clear the bank but leave the oscillator counts alone.
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    foreach (m[j]) m[j] = 32'h00000000;
    for (int c = 0; c < 4; c++) begin
      rd(PSR_RO_CNT0 + 8'(c), d);
      `CHK("count after reset", cnt[c], d)
    end
    rchk(PSR_DBG_CAUSE, ZERO_RESET);
    outs();
    close_out();
  end
endmodule
`undef CHK
`default_nettype wire
